/* touch_link_cfg.svh */
// constants for the touch sensor serial link and cascade logic
`ifndef TOUCH_LINK_CFG_SVH
`define TOUCH_LINK_CFG_SVH
`define ADDR_FIXED 6'h10
`define DIR_READ 1'b1
`define DIR_WRITE 1'b0
`define FIFO_DEPTH 16
`define FIFO_WIDTH 8
`define SAMPLE_DIV 8'h20
`define SCL_HALF 8'h04
`endif

/* touch_link_pkg.sv */
// types shared by both ends of the touch sensor link
`default_nettype none
package touch_link_pkg;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ACK = 3'b010,
		ST_RX = 3'b011,
		ST_TX = 3'b100,
		ST_TXACK = 3'b101,
		ST_WAIT = 3'b110
	} slave_state_t;
	typedef enum logic [2:0]
	{
		M_IDLE = 3'b000,
		M_START = 3'b001,
		M_BIT = 3'b010,
		M_ACK = 3'b011,
		M_STOP = 3'b100
	} master_state_t;
endpackage : touch_link_pkg
`default_nettype wire

/* touch_link_if.sv */
// serial link wires between the bus master and one sensor chip
`default_nettype none
interface touch_link_if;
	logic scl;
	logic sda_m_out;
	logic sda_m_oe;
	logic sda_s_out;
	logic sda_s_oe;
	wire logic sda_line;
	assign sda_line = !((sda_m_oe && !sda_m_out) || (sda_s_oe && !sda_s_out));
	modport master (output scl, output sda_m_out, output sda_m_oe, input sda_line);
	modport sensor (input scl, output sda_s_out, output sda_s_oe, input sda_line);
endinterface : touch_link_if
`default_nettype wire

/* byte_fifo.sv */
// small synchronous fifo with valid and ready on both sides
`include "touch_link_cfg.svh"
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = `FIFO_WIDTH,
	parameter int DEPTH = `FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	// refuse sizes the pointer arithmetic cannot serve
	if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH)
	begin : g_bad_size
		$error("fifo width must be positive and depth a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	wire do_wr = in_valid && in_ready;
	wire do_rd = out_valid && out_ready;
	assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data = mem[rd_ptr[AW-1:0]];
	// storage array
	always_ff @(posedge sys_clk)
		if (do_wr)
			mem[wr_ptr[AW-1:0]] <= in_data;
	// pointers
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			wr_ptr <= wr_ptr + (AW+1)'(do_wr);
			rd_ptr <= rd_ptr + (AW+1)'(do_rd);
		end
endmodule : byte_fifo
`default_nettype wire

/* touch_sensor_end.sv */
// sensor chip end: serial slave, direct read streaming and cascade logic
`include "touch_link_cfg.svh"
`default_nettype none
// Behaviour
// - master opens with start then address
// - write: address, command, data, each acknowledged
// - stop or repeated start ends access
// - read without command sends sensor state
// - direct read repeats sensor state until master nacks a byte
// - cascade: primary byte then secondary byte
// - cascaded stream alternates primary and secondary
// - master addresses primary for alternating read
// - secondary joins on primary address read
// - secondary otherwise answers select bit one
// - address is six fixed bits plus pin
// - primary drives sample clock out
// - secondary runs from imported sample clock
// - primary samples on internal rising edge
// - secondary samples on incoming falling edge
// - role comes from configuration setting
// - secondary interrupt ORs own and cascade input
// - bus interrupt mode needed only on secondary
// - address bit one follows select pin
// - address bit zero gives direction
module touch_sensor_end (
	input wire logic sys_clk,
	input wire logic rst,
	touch_link_if.sensor link,
	input wire logic address_select_pin,
	input wire logic cfg_secondary,
	input wire logic [7:0] sensor_inputs,
	input wire logic own_irq,
	input wire logic cascade_irq_in,
	input wire logic sample_clk_in,
	output logic sample_clk_out,
	output logic irq_out,
	output logic [7:0] sensor_state_byte,
	output logic [7:0] wr_command,
	output logic [7:0] wr_data,
	output logic wr_strobe
);
	touch_link_pkg::slave_state_t state;
	logic [1:0] scl_s, sda_s, clki_s;
	logic scl_d, sda_d, clki_d;
	logic [7:0] shreg;
	logic [3:0] bitcnt;
	logic [1:0] rx_count;
	logic is_read, shared, turn_mine, sda_oe;
	logic [7:0] div_cnt;
	logic int_clk;
	logic [1:0] oirq_s, cirq_s, asel_s;
	logic [7:0] sensor_state_byte_m, sensor_state_byte_q;
	// two flip-flop synchronisers on the pins
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
		begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			clki_s <= 2'h0;
			oirq_s <= 2'h0;
			cirq_s <= 2'h0;
			asel_s <= 2'h0;
			sensor_state_byte_m <= 8'h00;
			sensor_state_byte_q <= 8'h00;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			clki_d <= 1'b0;
		end
		else
		begin
			scl_s <= {scl_s[0], link.scl};
			sda_s <= {sda_s[0], link.sda_line};
			clki_s <= {clki_s[0], sample_clk_in};
			oirq_s <= {oirq_s[0], own_irq};
			cirq_s <= {cirq_s[0], cascade_irq_in};
			asel_s <= {asel_s[0], address_select_pin};
			sensor_state_byte_m <= sensor_inputs;
			sensor_state_byte_q <= sensor_state_byte_m;
			scl_d <= scl_s[1];
			sda_d <= sda_s[1];
			clki_d <= clki_s[1];
		end
	wire scl = scl_s[1];
	wire sda = sda_s[1];
	wire scl_rise = scl && !scl_d;
	wire scl_fall = !scl && scl_d;
	wire start_seen = scl && scl_d && sda_d && !sda;
	wire stop_seen = scl && scl_d && !sda_d && sda;
	wire [6:0] own_addr = {`ADDR_FIXED, asel_s[1]};
	wire [6:0] primary_addr = {`ADDR_FIXED, 1'b0};
	wire [7:0] rx_byte = {shreg[6:0], sda};
	// decode of the completed address byte held in shreg
	wire hit_own = shreg[7:1] == own_addr;
	wire hit_join = cfg_secondary && shreg[7:1] == primary_addr && shreg[0] == `DIR_READ;
	// a shared stream hands the turn over after every acknowledged byte;
	// primary role assumes a fitted secondary, so a lone chip should use its own read address as secondary
	wire next_turn = turn_mine ^ shared;
	wire next_int_clk = (div_cnt == `SAMPLE_DIV) ? !int_clk : int_clk;
	wire clki_fall = !clki_s[1] && clki_d;
	// primary samples on its own clock rising, secondary on imported falling edge
	wire sample_evt = cfg_secondary ? clki_fall : (int_clk == 1'b0 && div_cnt == `SAMPLE_DIV);
	//////////////////////////////////////////////////////////////////////
	// sample clock generation and sensor capture
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
		begin
			div_cnt <= 8'h00;
			int_clk <= 1'b0;
			sample_clk_out <= 1'b0;
			sensor_state_byte <= 8'h00;
			irq_out <= 1'b0;
		end
		else
		begin
			div_cnt <= (div_cnt == `SAMPLE_DIV) ? 8'h00 : div_cnt + 8'h01;
			int_clk <= next_int_clk;
			// the pin rises on the very edge at which the primary captures
			sample_clk_out <= cfg_secondary ? 1'b0 : next_int_clk;
			if (sample_evt)
				sensor_state_byte <= sensor_state_byte_q;
			irq_out <= oirq_s[1] || (cfg_secondary && cirq_s[1]);
		end
	//////////////////////////////////////////////////////////////////////
	// serial slave state machine
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
		begin
			state <= touch_link_pkg::ST_IDLE;
			shreg <= 8'h00;
			bitcnt <= 4'h0;
			rx_count <= 2'h0;
			is_read <= 1'b0;
			shared <= 1'b0;
			turn_mine <= 1'b0;
			sda_oe <= 1'b0;
			wr_command <= 8'h00;
			wr_data <= 8'h00;
			wr_strobe <= 1'b0;
		end
		else
		begin
			wr_strobe <= 1'b0;
			if (start_seen)
			begin
				state <= touch_link_pkg::ST_ADDR;
				bitcnt <= 4'h0;
				sda_oe <= 1'b0;
			end
			else if (stop_seen)
			begin
				state <= touch_link_pkg::ST_IDLE;
				sda_oe <= 1'b0;
			end
			else
				case (state)
					touch_link_pkg::ST_ADDR, touch_link_pkg::ST_RX:
						if (scl_rise)
						begin
							shreg <= rx_byte;
							bitcnt <= bitcnt + 4'h1;
						end
						else if (scl_fall && bitcnt == 4'h8)
						begin
							bitcnt <= 4'h0;
							if (state == touch_link_pkg::ST_ADDR)
							begin
								is_read <= shreg[0] == `DIR_READ;
								turn_mine <= !hit_join;
								shared <= hit_join || (!cfg_secondary && hit_own);
								rx_count <= 2'h0;
								if (hit_own || hit_join)
								begin
									sda_oe <= !hit_join;
									state <= touch_link_pkg::ST_ACK;
								end
								else
									state <= touch_link_pkg::ST_WAIT;
							end
							else
							begin
								sda_oe <= 1'b1;
								if (rx_count == 2'h0)
									wr_command <= shreg;
								else
								begin
									wr_data <= shreg;
									wr_strobe <= 1'b1;
								end
								rx_count <= (rx_count == 2'h0) ? 2'h1 : 2'h2;
								state <= touch_link_pkg::ST_ACK;
							end
						end
					touch_link_pkg::ST_ACK:
						if (scl_fall)
						begin
							sda_oe <= 1'b0;
							if (is_read)
							begin
								shreg <= sensor_state_byte;
								sda_oe <= turn_mine && !sensor_state_byte[7];
								state <= touch_link_pkg::ST_TX;
							end
							else
								state <= touch_link_pkg::ST_RX;
						end
					touch_link_pkg::ST_TX:
						if (scl_fall)
						begin
							bitcnt <= bitcnt + 4'h1;
							if (bitcnt == 4'h7)
							begin
								sda_oe <= 1'b0;
								state <= touch_link_pkg::ST_TXACK;
							end
							else
							begin
								shreg <= {shreg[6:0], 1'b0};
								sda_oe <= turn_mine && !shreg[6];
							end
						end
					touch_link_pkg::ST_TXACK:
						if (scl_rise)
						begin
							bitcnt <= 4'h0;
							if (sda)
								state <= touch_link_pkg::ST_WAIT;
						end
						else if (scl_fall && !sda_d)
						begin
							turn_mine <= next_turn;
							shreg <= sensor_state_byte;
							sda_oe <= next_turn && !sensor_state_byte[7];
							state <= touch_link_pkg::ST_TX;
						end
					touch_link_pkg::ST_WAIT:
						sda_oe <= 1'b0;
					default:
						state <= touch_link_pkg::ST_IDLE;
				endcase
		end
	// open drain: the pin only ever pulls low
	assign link.sda_s_out = 1'b0;
	assign link.sda_s_oe = sda_oe;
endmodule : touch_sensor_end
`default_nettype wire

/* touch_master_end.sv */
// bus master end: runs write and direct read accesses, queues read bytes
`include "touch_link_cfg.svh"
`default_nettype none
module touch_master_end (
	input wire logic sys_clk,
	input wire logic rst,
	touch_link_if.master link,
	input wire logic go,
	input wire logic go_read,
	input wire logic [6:0] target_addr,
	input wire logic [7:0] cmd_byte,
	input wire logic [7:0] data_byte,
	input wire logic [7:0] read_count,
	output logic busy,
	output logic nack_seen,
	output logic [7:0] rd_data,
	output logic rd_valid,
	input wire logic rd_ready
);
	touch_link_pkg::master_state_t state;
	logic [7:0] shreg, half, bytes_left;
	logic [1:0] phase, idx;
	logic [3:0] bitn;
	logic rd_mode, scl_r, sda_oe;
	logic [1:0] sda_s;
	logic [7:0] fifo_in;
	logic fifo_push;
	wire fifo_ready;
	wire tick = half == `SCL_HALF;
	wire sda_in = sda_s[1];
	// the byte queue stalls the master when full
	byte_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) byte_fifo_i (
		.sys_clk(sys_clk), .rst(rst), .in_data(fifo_in), .in_valid(fifo_push), .in_ready(fifo_ready),
		.out_data(rd_data), .out_valid(rd_valid), .out_ready(rd_ready));
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
			sda_s <= 2'h3;
		else
			sda_s <= {sda_s[0], link.sda_line};
	// access sequencer: start, address, command/data or read stream, stop
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
		begin
			state <= touch_link_pkg::M_IDLE;
			half <= 8'h00;
			phase <= 2'h0;
			idx <= 2'h0;
			bitn <= 4'h0;
			shreg <= 8'h00;
			bytes_left <= 8'h00;
			rd_mode <= 1'b0;
			scl_r <= 1'b1;
			sda_oe <= 1'b0;
			busy <= 1'b0;
			nack_seen <= 1'b0;
			fifo_in <= 8'h00;
			fifo_push <= 1'b0;
		end
		else
		begin
			fifo_push <= 1'b0;
			half <= tick ? 8'h00 : half + 8'h01;
			case (state)
				touch_link_pkg::M_IDLE:
					if (go)
					begin
						busy <= 1'b1;
						nack_seen <= 1'b0;
						rd_mode <= go_read;
						shreg <= {target_addr, go_read};
						bytes_left <= read_count;
						idx <= 2'h0;
						half <= 8'h00;
						state <= touch_link_pkg::M_START;
					end
				touch_link_pkg::M_START:
					if (tick)
					begin
						sda_oe <= 1'b1;
						phase <= 2'h0;
						bitn <= 4'h0;
						state <= touch_link_pkg::M_BIT;
					end
				touch_link_pkg::M_BIT:
					if (tick && fifo_ready)
					begin
						phase <= phase + 2'h1;
						if (phase == 2'h0)
						begin
							scl_r <= 1'b0;
						end
						else if (phase == 2'h1)
							sda_oe <= (rd_mode && idx != 2'h0) ? 1'b0 : !shreg[7];
						else if (phase == 2'h2)
							scl_r <= 1'b1;
						else
						begin
							shreg <= {shreg[6:0], sda_in};
							bitn <= bitn + 4'h1;
							if (bitn == 4'h7)
								state <= touch_link_pkg::M_ACK;
						end
					end
				touch_link_pkg::M_ACK:
					if (tick)
					begin
						phase <= phase + 2'h1;
						if (phase == 2'h0)
							scl_r <= 1'b0;
						else if (phase == 2'h1)
						begin
							// master acks read bytes except the last one
							sda_oe <= rd_mode && idx != 2'h0 && bytes_left > 8'h1;
							if (rd_mode && idx != 2'h0)
							begin
								fifo_in <= shreg;
								fifo_push <= 1'b1;
							end
						end
						else if (phase == 2'h2)
						begin
							scl_r <= 1'b1;
							if (!(rd_mode && idx != 2'h0) && sda_in)
								nack_seen <= 1'b1;
						end
						else
						begin
							bitn <= 4'h0;
							if (rd_mode && idx != 2'h0)
								bytes_left <= bytes_left - 8'h1;
							if (idx != 2'h3)
								idx <= idx + 2'h1;
							shreg <= (idx == 2'h0) ? cmd_byte : data_byte;
							if (nack_seen || (!rd_mode && idx == 2'h2) || (rd_mode && bytes_left <= 8'h1 && idx != 2'h0))
								state <= touch_link_pkg::M_STOP;
							else
								state <= touch_link_pkg::M_BIT;
						end
					end
				touch_link_pkg::M_STOP:
					if (tick)
					begin
						phase <= phase + 2'h1;
						if (phase == 2'h0)
							scl_r <= 1'b0;
						else if (phase == 2'h1)
							sda_oe <= 1'b1;
						else if (phase == 2'h2)
							scl_r <= 1'b1;
						else
						begin
							sda_oe <= 1'b0;
							busy <= 1'b0;
							state <= touch_link_pkg::M_IDLE;
						end
					end
				default:
					state <= touch_link_pkg::M_IDLE;
			endcase
		end
	assign link.scl = scl_r;
	assign link.sda_m_out = 1'b0;
	assign link.sda_m_oe = sda_oe;
endmodule : touch_master_end
`default_nettype wire

/* touch_link_assertions.sv */
// checker for the serial link between the bus master and the sensor chips
`include "touch_link_cfg.svh"
`default_nettype none
module touch_link_assertions (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda_m_out,
	input wire logic sda_m_oe,
	input wire logic sda_s_oe,
	input wire logic sda_line
);
////////////////////////////////////////////////////////////////////////////////
logic scl_q, sda_q, first, hit, rd;
logic [3:0] cnt;
logic [7:0] sh;
// bus conditions and the ninth clock of each byte
wire rise = scl && !scl_q;
wire start_c = scl && scl_q && sda_q && !sda_line;
wire stop_c = scl && scl_q && !sda_q && sda_line;
wire slot = rise && cnt == 4'h8;
wire ack_due = slot && (first ? sh[7:2] == `ADDR_FIXED : hit && !rd);
wire rd_slot = slot && !first && hit && rd;
wire nack_rd = rd_slot && sda_line;
// follows bit count, address match and direction of the access
always_ff @(posedge sys_clk or posedge rst)
begin
	if (rst)
	begin
		scl_q <= 1'b1;
		sda_q <= 1'b1;
		first <= 1'b0;
		hit <= 1'b0;
		rd <= 1'b0;
		cnt <= 4'h0;
		sh <= 8'h00;
	end
	else
	begin
		scl_q <= scl;
		sda_q <= sda_line;
		if (start_c)
		begin
			cnt <= 4'h0;
			first <= 1'b1;
			hit <= 1'b0;
			rd <= 1'b0;
		end
		else if (slot)
		begin
			cnt <= 4'h0;
			first <= 1'b0;
			hit <= first ? sh[7:2] == `ADDR_FIXED : hit;
			rd <= first ? sh[0] : rd;
		end
		else if (rise)
		begin
			cnt <= cnt + 4'h1;
			sh <= {sh[6:0], sda_line};
		end
	end
end
////////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge sys_clk);
endclocking
default disable iff (rst);
a_slave_steady_high: assert property ($changed(sda_s_oe) |-> !scl)
	else $error("slave data moved with clock high");
a_start_by_master: assert property (start_c |-> sda_m_oe && !sda_m_out)
	else $error("start not made by master");
a_stop_by_master: assert property (stop_c |-> $past(sda_m_oe) && !sda_m_oe)
	else $error("stop not made by master");
a_scl_low_span: assert property ($fell(scl) |=> !scl [*3])
	else $error("clock low phase too short");
a_idle_after_stop: assert property (stop_c |-> scl [*4])
	else $error("clock moved after stop");
a_ack_due: assert property (ack_due |-> !sda_line)
	else $error("byte not acknowledged");
a_read_slot_free: assert property (rd_slot |-> !sda_s_oe)
	else $error("slave drives master ack slot");
a_nack_release: assert property (nack_rd |=> !sda_s_oe [*8])
	else $error("slave holds data after nack");
// main scenarios seen
cover property (ack_due);
cover property (nack_rd);
cover property (stop_c);
endmodule : touch_link_assertions
`default_nettype wire

/* touch_sensor_i2c_cascade_tb_top.sv */
// bench: master end against a cascaded pair of sensor ends
`include "touch_link_cfg.svh"
`default_nettype none
module touch_sensor_i2c_cascade_tb_top;
timeunit 1ns;
timeprecision 1ns;
logic sys_clk, rst, go, go_read, rd_ready, own_p, own_s, sec;
logic [6:0] addr;
logic [7:0] cmd, dat, cnt, si_p, si_s;
wire logic busy, nack, rd_valid, ck_p, irq_p, irq_s, ws_p, ws_s, pm, pp, ps;
wire logic [7:0] rd_data, sb_p, sb_s, wc_s, wd_s;
int n_mismatch = 0;
int checked = 0;
int n_p = 0;
int n_s = 0;
touch_link_if lm();
touch_link_if lp();
touch_link_if ls();
////////////////////////////////////////////////////////////////////////////////
// wired-and bus: each end sees the pulls of the other two
assign pm = lm.sda_m_oe && !lm.sda_m_out;
assign pp = lp.sda_s_oe && !lp.sda_s_out;
assign ps = ls.sda_s_oe && !ls.sda_s_out;
assign lp.scl = lm.scl;
assign ls.scl = lm.scl;
assign lm.sda_s_oe = pp || ps;
assign lm.sda_s_out = 1'b0;
assign lp.sda_m_oe = pm || ps;
assign lp.sda_m_out = 1'b0;
assign ls.sda_m_oe = pm || pp;
assign ls.sda_m_out = 1'b0;
touch_master_end touch_master_end_i (.sys_clk(sys_clk), .rst(rst), .link(lm.master), .go(go),
	.go_read(go_read), .target_addr(addr), .cmd_byte(cmd), .data_byte(dat), .read_count(cnt),
	.busy(busy), .nack_seen(nack), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready));
touch_sensor_end touch_sensor_end_i (.sys_clk(sys_clk), .rst(rst), .link(lp.sensor),
	.address_select_pin(!sec), .cfg_secondary(!sec), .sensor_inputs(si_p), .own_irq(own_p),
	.cascade_irq_in(1'b0), .sample_clk_in(1'b0), .sample_clk_out(ck_p), .irq_out(irq_p),
	.sensor_state_byte(sb_p), .wr_command(), .wr_data(), .wr_strobe(ws_p));
touch_sensor_end touch_sensor_end_i_sec (.sys_clk(sys_clk), .rst(rst), .link(ls.sensor),
	.address_select_pin(sec), .cfg_secondary(sec), .sensor_inputs(si_s), .own_irq(own_s),
	.cascade_irq_in(irq_p), .sample_clk_in(ck_p), .sample_clk_out(), .irq_out(irq_s),
	.sensor_state_byte(sb_s), .wr_command(wc_s), .wr_data(wd_s), .wr_strobe(ws_s));
touch_link_assertions touch_link_assertions_i (.sys_clk(sys_clk), .rst(rst), .scl(lm.scl),
	.sda_m_out(lm.sda_m_out), .sda_m_oe(lm.sda_m_oe), .sda_s_oe(lm.sda_s_oe), .sda_line(lm.sda_line));
////////////////////////////////////////////////////////////////////////////////
// clock and write strobe counters
initial
begin
	sys_clk = 1'b0;
	forever #20 sys_clk = ~sys_clk;
end
always @(posedge sys_clk)
begin
	if (ws_p === 1'b1) n_p++;
	if (ws_s === 1'b1) n_s++;
end
////////////////////////////////////////////////////////////////////////////////
task tick;
	@(posedge sys_clk);
	#1;
endtask : tick
task chk(input logic ok, input string m);
	checked++;
	if (ok !== 1'b1)
	begin
		n_mismatch++;
		$display("BAD %0t %s", $time, m);
	end
endtask : chk
// one go pulse starts an access
task kick(input logic [6:0] a, input logic r, input logic [7:0] n);
	addr = a;
	go_read = r;
	cnt = n;
	go = 1'b1;
	tick;
	go = 1'b0;
	tick;
endtask : kick
task idle;
	int i;
	for (i = 0; i < 5000 && busy !== 1'b0; i++) tick;
	chk(busy === 1'b0, "busy stuck");
endtask : idle
task pop(input logic [7:0] e);
	int i;
	for (i = 0; i < 2000 && rd_valid !== 1'b1; i++) tick;
	chk(rd_valid === 1'b1 && rd_data === e, "read byte");
	rd_ready = 1'b1;
	tick;
	rd_ready = 1'b0;
	tick;
endtask : pop
////////////////////////////////////////////////////////////////////////////////
task t_sample;
	int i;
	si_p = 8'h5a;
	si_s = 8'hc3;
	for (i = 0; i < 500 && sb_p !== 8'h5a; i++) tick;
	chk(sb_p === 8'h5a && ck_p === 1'b1, "primary sample edge");
	for (i = 0; i < 500 && sb_s !== 8'hc3; i++) tick;
	chk(sb_s === 8'hc3 && ck_p === 1'b0, "secondary sample edge");
	si_p = 8'ha5;
	si_s = 8'h3c;
	repeat (200) tick;
	$display("test sample done");
endtask : t_sample
task t_irq;
	int i;
	for (i = 0; i < 4; i++)
	begin
		own_p = i[0];
		own_s = i[1];
		repeat (8) tick;
		chk(irq_p === i[0] && irq_s === (i[0] | i[1]), "interrupt merge");
	end
	$display("test irq done");
endtask : t_irq
task t_write;
	cmd = 8'h5a;
	dat = 8'hc3;
	kick({`ADDR_FIXED, 1'b1}, `DIR_WRITE, 8'h00);
	idle;
	chk(n_s === 1 && n_p === 0 && nack === 1'b0, "write to secondary");
	chk(wc_s === 8'h5a && wd_s === 8'hc3, "command or data");
	kick({`ADDR_FIXED, 1'b0}, `DIR_WRITE, 8'h00);
	idle;
	chk(n_p === 1 && n_s === 1, "write to primary");
	kick(7'h31, `DIR_WRITE, 8'h00);
	idle;
	chk(nack === 1'b1 && n_p === 1 && n_s === 1, "foreign address");
	$display("test write done");
endtask : t_write
task t_single;
	int i;
	kick({`ADDR_FIXED, 1'b1}, `DIR_READ, 8'h03);
	for (i = 0; i < 3; i++) pop(8'h3c);
	idle;
	$display("test single read done");
endtask : t_single
// eighteen bytes with the reader stalled: fifo fills, master waits
task t_stream;
	int i;
	kick({`ADDR_FIXED, 1'b0}, `DIR_READ, 8'h12);
	repeat (4000) tick;
	chk(busy === 1'b1 && rd_valid === 1'b1, "full fifo stall");
	for (i = 0; i < 18; i++) pop(i[0] ? 8'h3c : 8'ha5);
	idle;
	chk(rd_valid === 1'b0, "fifo drained");
	$display("test stream done");
endtask : t_stream
////////////////////////////////////////////////////////////////////////////////
task tally_and_finish;
	$display("checked %0d mismatches %0d", checked, n_mismatch);
	if (n_mismatch == 0 && checked > 0)
		$display("*** PASS ***");
	else
		$display("*** FAIL ***");
	$finish;
endtask : tally_and_finish
// watchdog against a hung access
initial
begin
	repeat (20000) @(posedge sys_clk);
	n_mismatch++;
	$display("BAD %0t watchdog", $time);
	tally_and_finish;
end
// main sequence
initial
begin
	rst = 1'b1;
	go = 1'b0;
	go_read = 1'b0;
	rd_ready = 1'b0;
	own_p = 1'b0;
	own_s = 1'b0;
	sec = 1'b1;
	addr = 7'h00;
	cmd = 8'h00;
	dat = 8'h00;
	cnt = 8'h00;
	si_p = 8'ha5;
	si_s = 8'h3c;
	repeat (6) @(posedge sys_clk);
	#1 rst = 1'b0;
	repeat (3) tick;
	t_sample;
	t_irq;
	t_write;
	t_single;
	t_stream;
	tally_and_finish;
end
endmodule : touch_sensor_i2c_cascade_tb_top
`default_nettype wire
